// *** phy_link_pkg.sv ***
// Shared constants and types for the MAC-side port link
package phy_link_pkg;
  localparam int NUM_PORTS = 8;
  localparam int SEG_BITS = 10;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] REP_LAST = 4'h9;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam int TX_CLK_LANE = 4;
  localparam int RX_CLK_LANE = 4;
  localparam int LINK_HALF_CYCLES = 4;
  localparam int MIN_LINK_HALF = 4;
  localparam int MAX_LINK_HALF = 255;
  localparam longint CLK_PERIOD_PS = 10000;
  localparam longint RESET_MIN_MS = 10;
  localparam longint PS_PER_MS = 1000000000;
  localparam int RESET_MIN_CYCLES = int'((RESET_MIN_MS * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [1:0] SEL_SS_SERIAL = 2'h1;
  typedef enum logic [1:0] {form_reduced, form_serial, form_ss_serial} form_t;
  function automatic form_t decode_form(input logic [1:0] sel);
    form_t f;
    f = form_serial;
    if (sel[1]) begin
      f = form_reduced;
    end else if (sel == SEL_SS_SERIAL) begin
      f = form_ss_serial;
    end
    return f;
  endfunction
endpackage

// *** phy_link_if.sv ***
// Link between the transceiver port block and its MAC
`timescale 1ns/1ps
interface phy_link_if import phy_link_pkg::*; #(parameter int PORTS = NUM_PORTS) ();
  // Board strap, driven by the bench
  logic crystal_input;
  // Reference clock pin, two drivers
  logic ref_dev_o;
  logic ref_dev_oe;
  logic ref_mac_o;
  logic ref_mac_oe;
  logic reference_clock_pin;
  assign reference_clock_pin = ref_dev_oe ? ref_dev_o : (ref_mac_oe & ref_mac_o);
  // Per-port data
  logic [PORTS-1:0] txd0;
  logic [PORTS-1:0] txd1;
  logic [PORTS-1:0] tx_en;
  logic [PORTS-1:0] rxd0;
  logic [PORTS-1:0] rxd1;
  logic [PORTS-1:0] crs_dv;
  // Shared
  logic sync;
  logic rx_sync;
  logic link_rst_n;
  modport device (
    input crystal_input, reference_clock_pin, txd0, txd1, tx_en, sync, link_rst_n,
    output ref_dev_o, ref_dev_oe, rxd0, rxd1, crs_dv, rx_sync
  );
  modport mac (
    input crystal_input, reference_clock_pin, rxd0, rxd1, crs_dv, rx_sync,
    output ref_mac_o, ref_mac_oe, txd0, txd1, tx_en, sync, link_rst_n
  );
endinterface

// *** phy_port_device.sv ***
// Transceiver end of the MAC-side port link
`timescale 1ns/1ps
module phy_port_device import phy_link_pkg::*; #(
  parameter int PORTS = NUM_PORTS,
  parameter int LINK_HALF = LINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Straps and rate
  input wire logic [1:0] mode_strap,
  input wire logic rate_10m,
  // Receive data from the media side
  input wire logic [PORTS-1:0] med_nonidle,
  input wire logic [2*PORTS-1:0] rx_dibit,
  input wire logic [SEG_BITS*PORTS-1:0] rx_seg,
  output logic rx_seg_taken,
  // Transmit data to the media side
  output logic [2*PORTS-1:0] tx_dibit,
  output logic [PORTS-1:0] tx_dv,
  output logic [SEG_BITS*PORTS-1:0] tx_seg,
  output logic tx_seg_valid,
  output form_t form,
  // Link
  phy_link_if.device lnk
);
  localparam int SW = 7 + 3 * PORTS;

  if (LINK_HALF < MIN_LINK_HALF || LINK_HALF > MAX_LINK_HALF) begin : bad_half
    $error("LINK_HALF out of range");
  end
  if (PORTS <= TX_CLK_LANE || PORTS <= RX_CLK_LANE) begin : bad_ports
    $error("PORTS too small for clock lanes");
  end

  // Pin synchroniser, three stages
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [SW-1:0] s3;
  logic [SW-1:0] f;
  wire [SW-1:0] raw = {mode_strap, lnk.crystal_input, lnk.link_rst_n, lnk.sync, lnk.reference_clock_pin,
                       lnk.crs_dv[RX_CLK_LANE], lnk.txd0, lnk.txd1, lnk.tx_en};

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      f <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      f <= (s2 & s3) | (f & (s2 | s3));
    end
  end

  wire [PORTS-1:0] txen_f = f[PORTS-1:0];
  wire [PORTS-1:0] txd1_f = f[2*PORTS-1:PORTS];
  wire [PORTS-1:0] txd0_f = f[3*PORTS-1:2*PORTS];
  wire rxc_f = f[3*PORTS];
  wire ref_f = f[3*PORTS+1];
  wire sync_f = f[3*PORTS+2];
  wire lrst_n_f = f[3*PORTS+3];
  wire xtal_f = f[3*PORTS+4];
  wire [1:0] strap_f = f[3*PORTS+6:3*PORTS+5];

  // Form latch at link reset release
  logic in_rst;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_rst <= 1'b1;
      form <= form_reduced;
    end else if (!lrst_n_f) begin
      in_rst <= 1'b1;
    end else if (in_rst) begin
      in_rst <= 1'b0;
      form <= decode_form(strap_f);
    end
  end

  wire run = ~in_rst;
  wire reduced = (form == form_reduced);
  wire serial = ~reduced;
  wire ss = (form == form_ss_serial);

  // Edge detection on link clocks
  logic ref_q;
  logic rxc_q;
  logic txc_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_q <= 1'b0;
      rxc_q <= 1'b0;
      txc_q <= 1'b0;
    end else begin
      ref_q <= ref_f;
      rxc_q <= rxc_f;
      txc_q <= txen_f[TX_CLK_LANE];
    end
  end
  wire ref_rise = ref_f & ~ref_q;
  wire tx_rise = run & (ss ? (txen_f[TX_CLK_LANE] & ~txc_q) : ref_rise);
  wire rx_rise = run & (ss ? (rxc_f & ~rxc_q) : ref_rise);

  // Clock divider, drives reference and receive clocks
  logic [7:0] div_cnt;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= 8'h00;
      lnk.ref_dev_o <= 1'b0;
      lnk.ref_dev_oe <= 1'b0;
    end else begin
      lnk.ref_dev_oe <= xtal_f;
      if (div_cnt == 8'(LINK_HALF - 1)) begin
        div_cnt <= 8'h00;
        lnk.ref_dev_o <= ~lnk.ref_dev_o;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // Transmit capture
  logic [3:0] tx_bit;
  logic [3:0] tx_rep;
  logic [SEG_BITS*PORTS-1:0] tx_sh;
  logic [SEG_BITS*PORTS-1:0] next_sh;
  logic [2*PORTS-1:0] next_dibit;
  wire [3:0] tx_idx = sync_f ? CNT_ZERO : tx_bit;
  wire tx_done = tx_rise & serial & (tx_idx == BIT_LAST);

  // Receive launch
  logic [3:0] rx_bit;
  logic [3:0] rx_rep;
  logic [SEG_BITS*PORTS-1:0] rx_cur;
  logic [PORTS-1:0] next_rxd0;
  logic [PORTS-1:0] even_rx;
  logic [PORTS-1:0] odd_rx;
  wire [3:0] rx_idx = (!ss && sync_f) ? CNT_ZERO : rx_bit;
  wire rx_load = rx_rise & serial & (rx_idx == CNT_ZERO) & (~rate_10m | (rx_rep == REP_LAST));
  wire [SEG_BITS*PORTS-1:0] rx_src = rx_load ? rx_seg : rx_cur;
  wire [PORTS-1:0] clk_lane = PORTS'(1) << RX_CLK_LANE;

  for (genvar p = 0; p < PORTS; p++) begin : lane
    assign next_sh[p*SEG_BITS +: SEG_BITS] = {txd0_f[p], tx_sh[p*SEG_BITS+1 +: SEG_BITS-1]};
    assign next_dibit[2*p +: 2] = {txd1_f[p], txd0_f[p]};
    assign next_rxd0[p] = rx_src[p*SEG_BITS + int'(rx_idx)];
    assign even_rx[p] = rx_dibit[2*p];
    assign odd_rx[p] = rx_dibit[2*p+1];
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_bit <= CNT_ZERO;
      tx_rep <= CNT_ZERO;
      tx_sh <= '0;
      tx_seg <= '0;
      tx_seg_valid <= 1'b0;
      tx_dibit <= '0;
      tx_dv <= '0;
    end else begin
      tx_seg_valid <= tx_done & (~rate_10m | (tx_rep == CNT_ZERO));
      if (tx_rise & reduced) begin
        tx_dibit <= next_dibit;
        tx_dv <= txen_f;
      end
      if (tx_rise & serial) begin
        tx_bit <= (tx_idx == BIT_LAST) ? CNT_ZERO : tx_idx + CNT_ONE;
        tx_sh <= next_sh;
      end
      if (tx_done) begin
        tx_seg <= next_sh;
        tx_rep <= (~rate_10m || tx_rep == REP_LAST) ? CNT_ZERO : tx_rep + CNT_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_bit <= CNT_ZERO;
      rx_rep <= REP_LAST;
      rx_cur <= '0;
      rx_seg_taken <= 1'b0;
      lnk.rxd0 <= '0;
      lnk.rxd1 <= '0;
      lnk.rx_sync <= 1'b0;
    end else begin
      rx_seg_taken <= rx_load;
      if (rx_load) begin
        rx_cur <= rx_seg;
      end
      if (serial) begin
        lnk.rxd1 <= '0;
      end else if (rx_rise) begin
        lnk.rxd1 <= odd_rx;
      end
      if (rx_rise & serial) begin
        rx_bit <= (rx_idx == BIT_LAST) ? CNT_ZERO : rx_idx + CNT_ONE;
        lnk.rxd0 <= next_rxd0;
        lnk.rx_sync <= ss & (rx_idx == CNT_ZERO);
        if (rx_idx == CNT_ZERO) begin
          rx_rep <= ~rate_10m ? REP_LAST : ((rx_rep == REP_LAST) ? CNT_ZERO : rx_rep + CNT_ONE);
        end
      end else if (rx_rise & reduced) begin
        lnk.rxd0 <= even_rx;
        lnk.rx_sync <= 1'b0;
      end
    end
  end

  // Carrier sense and receive clock lane
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk.crs_dv <= '0;
    end else if (reduced) begin
      lnk.crs_dv <= med_nonidle;
    end else if (ss && lnk.ref_dev_o) begin
      lnk.crs_dv <= clk_lane;
    end else begin
      lnk.crs_dv <= '0;
    end
  end
endmodule // phy_port_device

// *** phy_port_mac.sv ***
// MAC end of the port link
`timescale 1ns/1ps
module phy_port_mac import phy_link_pkg::*; #(
  parameter int PORTS = NUM_PORTS,
  parameter int LINK_HALF = LINK_HALF_CYCLES,
  parameter int RESET_HOLD = RESET_MIN_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Form and rate
  input wire logic [1:0] mode_sel,
  input wire logic rate_10m,
  // Transmit from the MAC core
  input wire logic [2*PORTS-1:0] tx_dibit,
  input wire logic [PORTS-1:0] tx_en_in,
  input wire logic [SEG_BITS*PORTS-1:0] tx_seg,
  output logic tx_seg_taken,
  // Receive to the MAC core
  output logic [2*PORTS-1:0] rx_dibit,
  output logic [PORTS-1:0] rx_dv,
  output logic [SEG_BITS*PORTS-1:0] rx_seg,
  output logic rx_seg_valid,
  output form_t form,
  // Link
  phy_link_if.mac lnk
);
  localparam int SW = 5 + 3 * PORTS;

  if (LINK_HALF < MIN_LINK_HALF || LINK_HALF > MAX_LINK_HALF) begin : bad_half
    $error("LINK_HALF out of range");
  end
  if (RESET_HOLD < 1 || RESET_HOLD >= (1 << 24)) begin : bad_hold
    $error("RESET_HOLD out of range");
  end
  if (PORTS <= TX_CLK_LANE || PORTS <= RX_CLK_LANE) begin : bad_ports
    $error("PORTS too small for clock lanes");
  end

  // Pin synchroniser, three stages
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [SW-1:0] s3;
  logic [SW-1:0] f;
  wire [SW-1:0] raw = {lnk.crystal_input, lnk.reference_clock_pin, lnk.tx_en[TX_CLK_LANE], lnk.sync,
                       lnk.rx_sync, lnk.rxd0, lnk.rxd1, lnk.crs_dv};
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      f <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      f <= (s2 & s3) | (f & (s2 | s3));
    end
  end
  wire [PORTS-1:0] crs_f = f[PORTS-1:0];
  wire [PORTS-1:0] rxd1_f = f[2*PORTS-1:PORTS];
  wire [PORTS-1:0] rxd0_f = f[3*PORTS-1:2*PORTS];
  wire rxsync_f = f[3*PORTS];
  wire sync_f = f[3*PORTS+1];
  wire txc_f = f[3*PORTS+2];
  wire ref_f = f[3*PORTS+3];
  wire xtal_f = f[3*PORTS+4];

  // Link reset hold and form latch
  logic [23:0] rst_cnt;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt <= 24'h000000;
      lnk.link_rst_n <= 1'b0;
      form <= form_reduced;
    end else if (!lnk.link_rst_n) begin
      if (rst_cnt == 24'(RESET_HOLD - 1)) begin
        lnk.link_rst_n <= 1'b1;
        form <= decode_form(mode_sel);
      end else begin
        rst_cnt <= rst_cnt + 24'h000001;
      end
    end
  end
  wire run = lnk.link_rst_n;
  wire reduced = (form == form_reduced);
  wire serial = ~reduced;
  wire ss = (form == form_ss_serial);

  // Edge detection
  logic ref_q;
  logic txc_q;
  logic rxc_q;
  logic sync_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_q <= 1'b0;
      txc_q <= 1'b0;
      rxc_q <= 1'b0;
    end else begin
      ref_q <= ref_f;
      txc_q <= txc_f;
      rxc_q <= crs_f[RX_CLK_LANE];
    end
  end
  wire ref_rise = ref_f & ~ref_q;
  wire tx_rise = run & (ss ? (txc_f & ~txc_q) : ref_rise);
  wire rx_rise = run & (ss ? (crs_f[RX_CLK_LANE] & ~rxc_q) : ref_rise);

  // Clock divider
  logic [7:0] div_cnt;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= 8'h00;
      lnk.ref_mac_o <= 1'b0;
      lnk.ref_mac_oe <= 1'b0;
    end else begin
      lnk.ref_mac_oe <= ~xtal_f;
      if (div_cnt == 8'(LINK_HALF - 1)) begin
        div_cnt <= 8'h00;
        lnk.ref_mac_o <= ~lnk.ref_mac_o;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // Lanes
  logic [3:0] tx_bit;
  logic [3:0] tx_rep;
  logic [SEG_BITS*PORTS-1:0] tx_cur;
  logic [3:0] rx_bit;
  logic [3:0] rx_rep;
  logic [SEG_BITS*PORTS-1:0] rx_sh;
  logic [SEG_BITS*PORTS-1:0] next_sh;
  logic [PORTS-1:0] next_txd0;
  logic [PORTS-1:0] even_tx;
  logic [PORTS-1:0] odd_tx;
  logic [2*PORTS-1:0] next_dibit;
  wire tx_load = tx_rise & serial & (tx_bit == CNT_ZERO) & (~rate_10m | (tx_rep == REP_LAST));
  wire [SEG_BITS*PORTS-1:0] tx_src = tx_load ? tx_seg : tx_cur;
  wire [3:0] rx_idx = (ss ? rxsync_f : sync_q) ? CNT_ZERO : rx_bit;
  wire rx_done = rx_rise & serial & (rx_idx == BIT_LAST);
  wire [PORTS-1:0] clk_lane = PORTS'(1) << TX_CLK_LANE;
  for (genvar p = 0; p < PORTS; p++) begin : lane
    assign next_txd0[p] = tx_src[p*SEG_BITS + int'(tx_bit)];
    assign even_tx[p] = tx_dibit[2*p];
    assign odd_tx[p] = tx_dibit[2*p+1];
    assign next_sh[p*SEG_BITS +: SEG_BITS] = {rxd0_f[p], rx_sh[p*SEG_BITS+1 +: SEG_BITS-1]};
    assign next_dibit[2*p +: 2] = {rxd1_f[p], rxd0_f[p]};
  end

  // Transmit launch
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_bit <= CNT_ZERO;
      tx_rep <= REP_LAST;
      tx_cur <= '0;
      tx_seg_taken <= 1'b0;
      lnk.txd0 <= '0;
      lnk.txd1 <= '0;
      lnk.sync <= 1'b0;
    end else begin
      tx_seg_taken <= tx_load;
      if (tx_load) begin
        tx_cur <= tx_seg;
      end
      if (tx_rise & serial) begin
        tx_bit <= (tx_bit == BIT_LAST) ? CNT_ZERO : tx_bit + CNT_ONE;
        lnk.txd0 <= next_txd0;
        lnk.txd1 <= '0;
        lnk.sync <= (tx_bit == CNT_ZERO);
        if (tx_bit == CNT_ZERO) begin
          tx_rep <= ~rate_10m ? REP_LAST : ((tx_rep == REP_LAST) ? CNT_ZERO : tx_rep + CNT_ONE);
        end
      end else if (tx_rise & reduced) begin
        lnk.txd0 <= even_tx;
        lnk.txd1 <= odd_tx;
        lnk.sync <= 1'b0;
      end
    end
  end

  // Transmit enables and transmit clock lane
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lnk.tx_en <= '0;
    end else if (reduced) begin
      if (tx_rise) begin
        lnk.tx_en <= tx_en_in;
      end
    end else if (ss && lnk.ref_mac_o) begin
      lnk.tx_en <= clk_lane;
    end else begin
      lnk.tx_en <= '0;
    end
  end

  // Receive capture
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_q <= 1'b0;
      rx_bit <= CNT_ZERO;
      rx_rep <= CNT_ZERO;
      rx_sh <= '0;
      rx_seg <= '0;
      rx_seg_valid <= 1'b0;
      rx_dibit <= '0;
      rx_dv <= '0;
    end else begin
      rx_seg_valid <= rx_done & (~rate_10m | (rx_rep == CNT_ZERO));
      if (ref_rise) begin
        sync_q <= sync_f;
      end
      if (rx_rise & reduced) begin
        rx_dibit <= next_dibit;
        rx_dv <= crs_f;
      end
      if (rx_rise & serial) begin
        rx_bit <= (rx_idx == BIT_LAST) ? CNT_ZERO : rx_idx + CNT_ONE;
        rx_sh <= next_sh;
      end
      if (rx_done) begin
        rx_seg <= next_sh;
        rx_rep <= (~rate_10m || rx_rep == REP_LAST) ? CNT_ZERO : rx_rep + CNT_ONE;
      end
    end
  end
endmodule // phy_port_mac

// *** phy_link_checker.sv ***
// Concurrent checks on the signals of the port link
`timescale 1ns/1ps
module phy_link_checker import phy_link_pkg::*; #(
  parameter int PORTS = NUM_PORTS,
  parameter int LINK_HALF = LINK_HALF_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Reference clock pin
  input wire logic crystal_input,
  input wire logic reference_clock_pin,
  input wire logic ref_dev_oe,
  input wire logic ref_mac_oe,
  // Link lanes
  input wire logic [PORTS-1:0] tx_en,
  input wire logic [PORTS-1:0] rxd1,
  input wire logic [PORTS-1:0] crs_dv,
  input wire logic sync,
  input wire logic rx_sync,
  input wire logic link_rst_n,
  // Form latched by the device
  input wire form_t form
);
  localparam int LH = LINK_HALF;
  localparam int SEG_GAP = 20 * LINK_HALF;
  wire [PORTS-1:0] crs_mask;
  assign crs_mask = (form == form_ss_serial) ? ~(PORTS'(1) << RX_CLK_LANE) : '1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence link_up;
    link_rst_n [*8];
  endsequence
  sequence serial_held;
    (form != form_reduced) [*2];
  endsequence
  sequence sync_start;
    $rose(sync);
  endsequence
  a_one_ref_driver: assert property (!(ref_dev_oe && ref_mac_oe))
    else $error("reference clock pin driven by both ends");
  a_dev_owns_ref: assert property (link_up ##0 crystal_input |-> ref_dev_oe)
    else $error("device not driving reference clock with crystal running");
  a_mac_owns_ref: assert property (link_up ##0 !crystal_input |-> ref_mac_oe)
    else $error("mac not driving reference clock without crystal");
  a_ref_half_period: assert property ($rose(reference_clock_pin) |-> ##LH $fell(reference_clock_pin))
    else $error("reference clock high time wrong");
  a_serial_rxd1_low: assert property (serial_held |-> rxd1 == '0)
    else $error("second receive bit not low in serial form");
  a_serial_crs_low: assert property (serial_held |-> (crs_dv & crs_mask) == '0)
    else $error("carrier sense not low in serial form");
  a_rx_sync_idle: assert property ((form != form_ss_serial) [*2] |-> !rx_sync)
    else $error("receive sync active outside source-sync form");
  a_sync_width: assert property (sync_start |-> sync [*8] ##1 !sync)
    else $error("sync not held exactly one link cycle");
  a_sync_spacing: assert property (sync_start |-> ##SEG_GAP $rose(sync))
    else $error("sync spacing is not ten link cycles");
  a_rx_sync_spacing: assert property ($rose(rx_sync) |-> ##SEG_GAP $rose(rx_sync))
    else $error("receive sync spacing is not ten link cycles");
  a_tx_clock_lane: assert property ((form == form_ss_serial) && $rose(tx_en[TX_CLK_LANE])
    |-> ##LH $fell(tx_en[TX_CLK_LANE]))
    else $error("transmit clock lane high time wrong");
  a_rx_clock_lane: assert property ((form == form_ss_serial) && $rose(crs_dv[RX_CLK_LANE])
    |-> ##LH $fell(crs_dv[RX_CLK_LANE]))
    else $error("receive clock lane high time wrong");
  a_link_rst_hold: assert property ($fell(sys_rst) |-> !link_rst_n [*8])
    else $error("link reset released too early");
endmodule // phy_link_checker

// *** octal_phy_mac_side_port_bench.sv ***
// Testbench joining both ends of the port link
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module octal_phy_mac_side_port_bench import phy_link_pkg::*;;
  localparam int LH = 4;
  localparam int HOLD = 20;
  localparam int SEGW = SEG_BITS * NUM_PORTS;
  localparam logic [SEGW-1:0] SEG_A = 80'h1234_5678_9abc_def0_1357;
  localparam logic [SEGW-1:0] SEG_B = 80'hc0de_4b1e_a5f0_3c69_8e27;
  int error_cnt = 0;
  int n_checks = 0;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] mode_strap = 2'h3;
  logic [1:0] mode_sel = 2'h3;
  logic rate_10m = 1'b0;
  logic [NUM_PORTS-1:0] med_nonidle = '0;
  logic [2*NUM_PORTS-1:0] dev_rx_dibit = '0;
  logic [SEGW-1:0] dev_rx_seg = '0;
  logic [2*NUM_PORTS-1:0] mac_tx_dibit = '0;
  logic [NUM_PORTS-1:0] mac_tx_en = '0;
  logic [SEGW-1:0] mac_tx_seg = '0;
  logic dev_rx_seg_taken, dev_tx_seg_valid, mac_tx_seg_taken, mac_rx_seg_valid;
  logic [2*NUM_PORTS-1:0] dev_tx_dibit, mac_rx_dibit;
  logic [NUM_PORTS-1:0] dev_tx_dv, mac_rx_dv;
  logic [SEGW-1:0] dev_tx_seg, mac_rx_seg;
  form_t dev_form, mac_form;
  always #5 ref_clk = ~ref_clk;
  phy_link_if #(.PORTS(NUM_PORTS)) lnk ();
  phy_port_device #(.PORTS(NUM_PORTS), .LINK_HALF(LH)) phy_port_device_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .mode_strap(mode_strap), .rate_10m(rate_10m),
    .med_nonidle(med_nonidle), .rx_dibit(dev_rx_dibit), .rx_seg(dev_rx_seg), .rx_seg_taken(dev_rx_seg_taken),
    .tx_dibit(dev_tx_dibit), .tx_dv(dev_tx_dv), .tx_seg(dev_tx_seg), .tx_seg_valid(dev_tx_seg_valid),
    .form(dev_form), .lnk(lnk));
  phy_port_mac #(.PORTS(NUM_PORTS), .LINK_HALF(LH), .RESET_HOLD(HOLD)) phy_port_mac_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .mode_sel(mode_sel), .rate_10m(rate_10m),
    .tx_dibit(mac_tx_dibit), .tx_en_in(mac_tx_en), .tx_seg(mac_tx_seg), .tx_seg_taken(mac_tx_seg_taken),
    .rx_dibit(mac_rx_dibit), .rx_dv(mac_rx_dv), .rx_seg(mac_rx_seg), .rx_seg_valid(mac_rx_seg_valid),
    .form(mac_form), .lnk(lnk));
  phy_link_checker #(.PORTS(NUM_PORTS), .LINK_HALF(LH)) phy_link_checker_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .crystal_input(lnk.crystal_input),
    .reference_clock_pin(lnk.reference_clock_pin), .ref_dev_oe(lnk.ref_dev_oe), .ref_mac_oe(lnk.ref_mac_oe),
    .tx_en(lnk.tx_en), .rxd1(lnk.rxd1), .crs_dv(lnk.crs_dv), .sync(lnk.sync), .rx_sync(lnk.rx_sync),
    .link_rst_n(lnk.link_rst_n), .form(dev_form));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Waits for a segment pulse (0 device tx, 1 mac rx), a load pulse (3 mac tx, 4 device rx) or a reference rise
  task automatic wait_ev(input int which, output int cyc);
    logic prev;
    logic hit;
    prev = lnk.reference_clock_pin;
    hit = 1'b0;
    cyc = 0;
    for (int n = 0; n < 3000 && !hit; n++) begin
      @(posedge ref_clk);
      #1;
      case (which)
        0: hit = (dev_tx_seg_valid === 1'b1);
        1: hit = (mac_rx_seg_valid === 1'b1);
        3: hit = (mac_tx_seg_taken === 1'b1);
        4: hit = (dev_rx_seg_taken === 1'b1);
        default: hit = (lnk.reference_clock_pin === 1'b1) && (prev === 1'b0);
      endcase
      prev = lnk.reference_clock_pin;
      cyc = n + 1;
    end
    if (!hit) begin
      error_cnt++;
      $display("[ERR] %0t wait ran out", $time);
      complete_run();
    end
  endtask

  task automatic do_reset(input logic [1:0] sel, input logic rate, input logic xtal, input form_t exp);
    int n;
    int c;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    mode_strap <= sel;
    mode_sel <= sel;
    rate_10m <= rate;
    lnk.crystal_input <= xtal;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (n = 0; n < 200 && lnk.link_rst_n !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK(lnk.link_rst_n, 1'b1)
    if (lnk.link_rst_n !== 1'b1) begin
      complete_run();
    end
    `CHK(n >= HOLD, 1'b1)
    repeat (2) wait_ev(2, c);
    `CHK(dev_form, exp)
    `CHK(mac_form, exp)
  endtask

  task automatic test_reduced(input logic xtal);
    int c;
    logic [2*NUM_PORTS-1:0] td, rd;
    logic [NUM_PORTS-1:0] te, md;
    do_reset(2'h2, 1'b0, xtal, form_reduced);
    `CHK(lnk.ref_dev_oe, xtal)
    `CHK(lnk.ref_mac_oe, ~xtal)
    for (int i = 0; i < 2; i++) begin
      td = i ? 16'h63c9 : 16'h9c36;
      rd = i ? 16'he1d2 : 16'h1e2d;
      te = i ? 8'ha5 : 8'h5a;
      md = i ? 8'hc3 : 8'h3c;
      @(posedge ref_clk);
      mac_tx_dibit <= td;
      mac_tx_en <= te;
      dev_rx_dibit <= rd;
      med_nonidle <= md;
      repeat (4) wait_ev(2, c);
      `CHK(dev_tx_dibit, td)
      `CHK(dev_tx_dv, te)
      `CHK(mac_rx_dibit, rd)
      `CHK(lnk.crs_dv, md)
      `CHK(mac_rx_dv, md)
    end
    @(posedge ref_clk);
    mode_strap <= 2'h0;
    mode_sel <= 2'h0;
    repeat (4) wait_ev(2, c);
    `CHK(dev_form, form_reduced)
    `CHK(mac_form, form_reduced)
    $display("reduced form test done, crystal %0d", xtal);
  endtask

  function automatic logic [SEGW-1:0] seg_out(input int which);
    return (which == 0) ? dev_tx_seg : mac_rx_seg;
  endfunction

  // First segment, spacing of reports, then a change of segment
  task automatic seg_run(input int which, input logic [SEGW-1:0] a_val, b_val, input int gap);
    int c;
    wait_ev(which, c);
    `CHK(seg_out(which), a_val)
    wait_ev(which, c);
    `CHK(c, gap)
    @(posedge ref_clk);
    if (which == 0) begin
      mac_tx_seg <= b_val;
    end else begin
      dev_rx_seg <= b_val;
    end
    repeat (3) wait_ev(which, c);
    `CHK(seg_out(which), b_val)
  endtask

  task automatic test_serial(input logic [1:0] sel, input logic rate, input form_t exp,
                             input logic [NUM_PORTS-1:0] mask);
    int c;
    int gap;
    gap = rate ? 200 * LH : 20 * LH;
    @(posedge ref_clk);
    mac_tx_seg <= SEG_A;
    dev_rx_seg <= SEG_B;
    mac_tx_en <= '1;
    mac_tx_dibit <= '1;
    do_reset(sel, rate, 1'b1, exp);
    seg_run(0, SEG_A, SEG_B, gap);
    seg_run(1, SEG_B, SEG_A, gap);
    wait_ev(3, c);
    wait_ev(3, c);
    `CHK(c, gap)
    wait_ev(4, c);
    wait_ev(4, c);
    `CHK(c, gap)
    `CHK(dev_tx_dv, 8'h00)
    `CHK(lnk.txd1, 8'h00)
    `CHK(lnk.rxd1, 8'h00)
    `CHK(lnk.crs_dv & mask, 8'h00)
    $display("serial test done, select %0d rate10 %0d", sel, rate);
  endtask

  initial begin
    test_reduced(1'b1);
    test_reduced(1'b0);
    test_serial(2'h0, 1'b0, form_serial, 8'hff);
    test_serial(2'h0, 1'b1, form_serial, 8'hff);
    test_serial(2'h1, 1'b0, form_ss_serial, 8'hef);
    test_serial(2'h1, 1'b1, form_ss_serial, 8'hef);
    complete_run();
  end
endmodule // octal_phy_mac_side_port_bench
